// *** vgc_bank.sv ***
/*
  Global control and status register bank, dual ported: local processor
  port and short I/O slave port through vgc_bus_if.
  Assumes one clock; board fail and strap pins arrive asynchronously.
*/
// Summary of operation
// RQ1 - Low signal: remote sets, local clears
// RQ2 - Low signal raises level 1 request
// RQ3 - High signal: remote sets, local clears
// RQ4 - High signal raises level 5 request
// RQ5 - Signals reset clear; need mapped set
// RQ6 - Status bit 4 mirrors board fail
// RQ7 - Inhibit bit releases fail line drive
// RQ8 - Bit 6 reports controller strap
// RQ9 - Reset-and-hold bit holds board reset
// RQ10 - Own board reset keeps hold bit
// RQ11 - Hold bit held at least 35 us
// RQ12 - Avoid hold while local remote cycle
// RQ13 - Identifier local RW, remote read-only
// RQ14 - Mailbox zero RW, resets to ones
// RQ15 - Mailboxes one-four RW, reset to zeros
// RQ16 - Base nibble forms address bits 4-7
// RQ17 - All-ones nibble disables remote side
// RQ18 - Same-cycle accesses serialised, none lost; code drops the remote mailbox write and the local signal clear
// RQ19 - Zero writes leave signal bits unchanged
`timescale 1ns/100ps
`default_nettype none

module vgc_bank
  import vgc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,          // Bus system reset
  vgc_bus_if.bank bus,
  input wire logic [3:0] i_base_nibble, // Base nibble from config logic
  input wire logic [31:0] i_loc_addr,   // Local processor address
  input wire logic [7:0] i_loc_wdata,
  input wire logic i_loc_strobe,
  input wire logic i_loc_write,
  output logic [7:0] o_loc_rdata,
  output logic o_loc_ack,
  output logic o_loc_hit,
  input wire logic i_low_irq_enable,
  input wire logic i_high_irq_enable,
  input wire logic i_board_fail_pin,    // Board fail line level, high active
  input wire logic i_strap_pin,         // Controller select header strap
  input wire logic i_fail_request,      // Local wish to drive fail line
  output logic o_fail_line_drive,
  output logic o_board_hold_reset,
  output logic [2:0] o_irq_level
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic low_signal;     // Low priority signal bit
  logic high_signal;    // High priority signal bit
  logic fail_inhibit;   // Fail line inhibit
  logic reset_hold;     // Reset-and-hold bit
  logic [7:0] board_ident;
  logic [7:0] mailbox [5];
  logic [2:0] fail_sync; // Board fail synchroniser
  logic [2:0] strap_sync; // Strap synchroniser
  logic fail_seen;       // Filtered board fail
  logic strap_seen;      // Filtered strap

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic mapped;          // Set answers remote accesses
  logic rem_hit;
  logic [2:0] rem_sel;
  logic rem_wr;
  logic loc_wr;
  logic [2:0] loc_sel;
  logic loc_in_range;

  // RQ17 all-ones disables
  assign mapped = (i_base_nibble != RST_BASE_NIBBLE);
  // RQ16 base nibble decode
  assign rem_sel = bus.addr[ADDR_SEL_LSB +: 3];
  assign rem_hit = mapped && (bus.addr[15:8] == SHORT_IO_UPPER_ZERO)
                   && (bus.addr[ADDR_BASE_LSB +: 4] == i_base_nibble)
                   && bus.addr[0] && (rem_sel != 3'h0);
  assign rem_wr = bus.strobe && bus.write && rem_hit;
  assign bus.hit = rem_hit;

  // Local decode over odd addresses of the bank
  assign loc_in_range = (i_loc_addr >= LOC_CTRL_STATUS_ONE) && (i_loc_addr <= LOC_MAILBOX_FOUR)
                        && i_loc_addr[0];
  assign loc_sel = i_loc_addr[ADDR_SEL_LSB +: 3];
  assign loc_wr = i_loc_strobe && i_loc_write && loc_in_range;
  assign o_loc_hit = loc_in_range;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_clock) begin
    fail_sync <= {fail_sync[1:0], i_board_fail_pin};
    strap_sync <= {strap_sync[1:0], i_strap_pin};
  end

  // Change counts when stages two and three agree
  always_ff @(posedge i_clock) begin
    if (fail_sync[1] == fail_sync[2]) begin
      fail_seen <= fail_sync[2];
    end
    if (strap_sync[1] == strap_sync[2]) begin
      strap_seen <= strap_sync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Signal bits
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      // RQ5 reset clears signals
      low_signal <= 1'b0;
      high_signal <= 1'b0;
    end else begin
      // RQ18 remote set beats local clear
      // RQ1 low bit set/clear
      // RQ19 zero writes ignored
      if (rem_wr && rem_sel == SEL_CTRL_STATUS_ONE && bus.wdata[BIT_LOW_SIGNAL]) begin
        low_signal <= 1'b1;
      end else if (loc_wr && loc_sel == SEL_CTRL_STATUS_ONE && i_loc_wdata[BIT_LOW_SIGNAL]) begin
        low_signal <= 1'b0;
      end
      // RQ3 high bit set/clear
      if (rem_wr && rem_sel == SEL_CTRL_STATUS_ONE && bus.wdata[BIT_HIGH_SIGNAL]) begin
        high_signal <= 1'b1;
      end else if (loc_wr && loc_sel == SEL_CTRL_STATUS_ONE && i_loc_wdata[BIT_HIGH_SIGNAL]) begin
        high_signal <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Inhibit and reset-and-hold, remote writable only
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      // RQ7 reset clears inhibit
      fail_inhibit <= 1'b0;
      // RQ9 reset clears hold
      reset_hold <= 1'b0;
    end else if (rem_wr && rem_sel == SEL_CTRL_STATUS_ONE) begin
      // RQ10 board hold leaves bit
      fail_inhibit <= bus.wdata[BIT_FAIL_INHIBIT];
      reset_hold <= bus.wdata[BIT_RESET_HOLD];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Identifier and mailboxes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      // RQ13 identifier clears
      board_ident <= RST_BOARD_IDENT;
    end else if (loc_wr && loc_sel == SEL_BOARD_IDENT) begin
      // RQ13 local write only
      board_ident <= i_loc_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      // RQ14 mailbox zero ones
      mailbox[0] <= RST_MAILBOX_ZERO;
      // RQ15 others zeros
      for (int k = 1; k < 5; k++) begin
        mailbox[k] <= RST_MAILBOX_REST;
      end
    end else begin
      for (int k = 0; k < 5; k++) begin
        // RQ18 local write wins tie
        if (loc_wr && loc_sel == SEL_MAILBOX_ZERO + 3'(k)) begin
          mailbox[k] <= i_loc_wdata;
        end else if (rem_wr && rem_sel == SEL_MAILBOX_ZERO + 3'(k)) begin
          mailbox[k] <= bus.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  function automatic logic [7:0] read_value(input logic [2:0] sel);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      SEL_CTRL_STATUS_ONE: begin
        v[BIT_LOW_SIGNAL] = low_signal;
        v[BIT_HIGH_SIGNAL] = high_signal;
        // RQ6 fail mirror
        v[BIT_BOARD_FAIL] = fail_seen;
        v[BIT_FAIL_INHIBIT] = fail_inhibit;
        // RQ8 strap report
        v[BIT_STRAP] = strap_seen;
        v[BIT_RESET_HOLD] = reset_hold;
      end
      SEL_BOARD_IDENT: v = board_ident;
      SEL_MAILBOX_ZERO: v = mailbox[0];
      SEL_MAILBOX_ONE: v = mailbox[1];
      SEL_MAILBOX_TWO: v = mailbox[2];
      SEL_MAILBOX_THREE: v = mailbox[3];
      SEL_MAILBOX_FOUR: v = mailbox[4];
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Answers one cycle after strobe
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_loc_rdata <= 8'h00;
      o_loc_ack <= 1'b0;
      bus.rdata <= 8'h00;
      bus.ack <= 1'b0;
    end else begin
      o_loc_ack <= i_loc_strobe && loc_in_range;
      bus.ack <= bus.strobe && rem_hit;
      if (i_loc_strobe && loc_in_range) begin
        o_loc_rdata <= read_value(loc_sel);
      end
      if (bus.strobe && rem_hit) begin
        bus.rdata <= read_value(rem_sel);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // RQ7 inhibit gates drive
  assign o_fail_line_drive = i_fail_request && !fail_inhibit;
  // RQ9 hold board reset
  assign o_board_hold_reset = reset_hold;

  // RQ2 level 1 request
  // RQ4 level 5 request, higher wins
  always_comb begin
    o_irq_level = 3'h0;
    if (mapped && high_signal && i_high_irq_enable) begin
      o_irq_level = IRQ_LEVEL_HIGH;
    end else if (mapped && low_signal && i_low_irq_enable) begin
      o_irq_level = IRQ_LEVEL_LOW;
    end
  end

endmodule

`default_nettype wire

// *** vgc_pkg.sv ***
/*
  Package for the global register bank: local offsets, short I/O decode
  fields, bit positions, reset values and timing constants.
  Assumes a single 200 MHz clock domain on both ends.
*/
package vgc_pkg;

  // Local processor byte addresses of the bank
  localparam logic [31:0] LOC_CTRL_STATUS_ONE = 32'hfffe2023;
  localparam logic [31:0] LOC_BOARD_IDENT = 32'hfffe2025;
  localparam logic [31:0] LOC_MAILBOX_ZERO = 32'hfffe2027;
  localparam logic [31:0] LOC_MAILBOX_ONE = 32'hfffe2029;
  localparam logic [31:0] LOC_MAILBOX_TWO = 32'hfffe202b;
  localparam logic [31:0] LOC_MAILBOX_THREE = 32'hfffe202d;
  localparam logic [31:0] LOC_MAILBOX_FOUR = 32'hfffe202f;

  // Register select values on short I/O address bits 3..1
  localparam logic [2:0] SEL_CTRL_STATUS_ONE = 3'h1;
  localparam logic [2:0] SEL_BOARD_IDENT = 3'h2;
  localparam logic [2:0] SEL_MAILBOX_ZERO = 3'h3;
  localparam logic [2:0] SEL_MAILBOX_ONE = 3'h4;
  localparam logic [2:0] SEL_MAILBOX_TWO = 3'h5;
  localparam logic [2:0] SEL_MAILBOX_THREE = 3'h6;
  localparam logic [2:0] SEL_MAILBOX_FOUR = 3'h7;

  // Short I/O address field positions
  localparam int ADDR_SEL_LSB = 1;
  localparam int ADDR_BASE_LSB = 4;
  localparam logic [7:0] SHORT_IO_UPPER_ZERO = 8'h00;

  // Control/status one field positions
  localparam int BIT_LOW_SIGNAL = 0;
  localparam int BIT_HIGH_SIGNAL = 1;
  localparam int BIT_BOARD_FAIL = 4;
  localparam int BIT_FAIL_INHIBIT = 5;
  localparam int BIT_STRAP = 6;
  localparam int BIT_RESET_HOLD = 7;

  // Reset values
  localparam logic [3:0] RST_BASE_NIBBLE = 4'hf;
  localparam logic [7:0] RST_BOARD_IDENT = 8'h00;
  localparam logic [7:0] RST_MAILBOX_ZERO = 8'hff;
  localparam logic [7:0] RST_MAILBOX_REST = 8'h00;

  // Interrupt levels presented to the local processor
  localparam logic [2:0] IRQ_LEVEL_LOW = 3'h1;
  localparam logic [2:0] IRQ_LEVEL_HIGH = 3'h5;

  // Least reset-and-hold time
  localparam int CLOCK_MHZ = 200;
  localparam int HOLD_MIN_US = 35;
  localparam int HOLD_MIN_CYCLES = HOLD_MIN_US * CLOCK_MHZ;

endpackage

// *** vgc_bus_if.sv ***
/*
  Interface joining the register bank to a remote bus master model end.
  Holds the short I/O slave signals; no clocking block.
*/
`timescale 1ns/100ps
`default_nettype none

interface vgc_bus_if;
  logic [15:0] addr;   // Short I/O address
  logic [7:0] wdata;   // Write data
  logic [7:0] rdata;   // Read data from the bank
  logic strobe;        // Access request, one cycle
  logic write;         // Write when high
  logic ack;           // Answer, one cycle
  logic hit;           // Address decoded by the bank

  // Documented device end
  modport bank (input addr, input wdata, input strobe, input write, output rdata, output ack, output hit);
  // Remote master end
  modport master (output addr, output wdata, output strobe, output write, input rdata, input ack, input hit);
endinterface

`default_nettype wire

// *** vgc_master.sv ***
/*
  Remote bus master end: issues single short I/O accesses to the bank
  and times the reset-and-hold pulse. Assumes the bank answers in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module vgc_master
  import vgc_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_MIN_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  vgc_bus_if.master bus,
  input wire logic i_req,            // Start an access
  input wire logic i_req_write,
  input wire logic [15:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  input wire logic i_local_busy,     // Local side running a remote cycle
  output logic o_busy,
  output logic o_done,
  output logic o_miss,               // No bank answered
  output logic [7:0] o_rdata
);

  typedef enum {ST_IDLE, ST_WAIT, ST_HOLD} vgc_state_t;
  vgc_state_t state;
  logic [31:0] hold_count;  // Cycles since hold bit set
  logic hold_write;         // Current write targets control/status one, which holds the hold bit
  logic hold_active;

  assign hold_write = i_req_write && i_req_addr[0]
                      && i_req_addr[ADDR_SEL_LSB +: 3] == SEL_CTRL_STATUS_ONE;

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      bus.strobe <= 1'b0;
      bus.write <= 1'b0;
      bus.addr <= 16'h0000;
      bus.wdata <= 8'h00;
      o_done <= 1'b0;
      o_miss <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      bus.strobe <= 1'b0;
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          // RQ12 wait out local cycle
          // RQ11 no clear of hold early
          if (i_req && !(hold_write && i_req_wdata[BIT_RESET_HOLD] && i_local_busy)
              && !(hold_write && !i_req_wdata[BIT_RESET_HOLD] && hold_active
                   && hold_count < 32'(HOLD_CYCLES))) begin
            bus.strobe <= 1'b1;
            bus.write <= i_req_write;
            bus.addr <= i_req_addr;
            bus.wdata <= i_req_wdata;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          // Answer is due now
          o_done <= 1'b1;
          o_miss <= !bus.ack;
          o_rdata <= bus.rdata;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hold timer
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hold_active <= 1'b0;
      hold_count <= 32'h0;
    end else if (bus.strobe && bus.write && bus.hit && bus.addr[ADDR_SEL_LSB +: 3] == SEL_CTRL_STATUS_ONE) begin
      hold_active <= bus.wdata[BIT_RESET_HOLD];
      hold_count <= 32'h0;
    end else if (hold_active && hold_count != 32'hffffffff) begin
      hold_count <= hold_count + 32'h1;
    end
  end

  assign o_busy = (state != ST_IDLE);

endmodule

`default_nettype wire

// *** vgc_chk.sv ***
/*
  Checker for the short I/O link between the register bank and the master.
  Assumes one clock and the link signals fed in as plain inputs.
*/
`timescale 1ns/100ps
`default_nettype none

module vgc_chk #(
  parameter int HOLD_CYCLES = 20
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_base_nibble,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic strobe,
  input wire logic write,
  input wire logic ack,
  input wire logic hit
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////
  logic held; // Hold bit set remotely
  int cnt; // Cycles since hold was set
  wire logic ctrl_wr = strobe && hit && write && addr[3:1] == 3'h1; // Remote control write

  // Track hold span
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      held <= 1'b0;
      cnt <= 0;
    end else if (ctrl_wr && wdata[7] && !held) begin
      held <= 1'b1;
      cnt <= 0;
    end else if (ctrl_wr && !wdata[7]) begin
      held <= 1'b0;
    end else if (held) begin
      cnt <= cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  AST_DECODE:
  assert property (strobe |-> hit == (addr[15:8] == 8'h00 && addr[7:4] == i_base_nibble
    && i_base_nibble != 4'hf && addr[0] && addr[3:1] != 3'h0)) else $error("decode wrong");
  AST_UNMAPPED:
  assert property (i_base_nibble == 4'hf |-> !hit) else $error("unmapped set answered");
  AST_ACK_AFTER_HIT:
  assert property (strobe && hit |=> ack) else $error("no answer to hit");
  AST_NO_ACK_MISS:
  assert property (!(strobe && hit) |=> !ack) else $error("answer without hit");
  AST_ACK_ONE:
  assert property (ack |=> !ack) else $error("answer too long");
  AST_STROBE_SPACING:
  assert property (strobe |=> !strobe [*2]) else $error("requests too close");
  AST_ACK_CAUSE:
  assert property ($rose(ack) |-> $past(strobe)) else $error("answer without request");
  AST_HOLD_TIME:
  assert property (ctrl_wr && !wdata[7] && held |-> cnt >= HOLD_CYCLES - 4) else $error("hold too short");

  // Main traffic kinds
  cover property (strobe && hit && write);
  cover property (strobe && hit && !write);
  cover property (strobe && !hit);
endmodule

`default_nettype wire

// *** testbench.sv ***
/*
  Self-checking bench: bank and master joined by the link interface.
  Assumes a 200 MHz clock and a shortened hold time of 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import vgc_pkg::*;
  logic i_clock, i_sys_rst, loc_strobe, loc_write, loc_ack, low_en, high_en, fail_pin, strap;
  logic fail_req, req, rq_write, local_busy, m_done, m_miss, fail_drive, hold;
  logic busy; // Master sequencer busy
  logic loc_hit; // Local decode hit
  logic [3:0] nib; // Base nibble
  logic [31:0] loc_addr;
  logic [7:0] loc_wdata, loc_rdata, m_rdata, rq_wdata;
  logic [15:0] rq_addr;
  logic [2:0] irq;
  int miscompares, tests_run;
  vgc_bus_if bif();

  ////////////////////////////////////////////////////////////////
  vgc_bank vgc_bank_i(.i_clock, .i_sys_rst, .bus(bif), .i_base_nibble(nib), .i_loc_addr(loc_addr),
    .i_loc_wdata(loc_wdata), .i_loc_strobe(loc_strobe), .i_loc_write(loc_write), .o_loc_rdata(loc_rdata),
    .o_loc_ack(loc_ack), .o_loc_hit(loc_hit), .i_low_irq_enable(low_en), .i_high_irq_enable(high_en),
    .i_board_fail_pin(fail_pin), .i_strap_pin(strap), .i_fail_request(fail_req),
    .o_fail_line_drive(fail_drive), .o_board_hold_reset(hold), .o_irq_level(irq));
  vgc_master #(.HOLD_CYCLES(20)) vgc_master_i(.i_clock, .i_sys_rst, .bus(bif), .i_req(req),
    .i_req_write(rq_write), .i_req_addr(rq_addr), .i_req_wdata(rq_wdata), .i_local_busy(local_busy),
    .o_busy(busy), .o_done(m_done), .o_miss(m_miss), .o_rdata(m_rdata));
  vgc_chk #(.HOLD_CYCLES(20)) vgc_chk_i(.i_clock, .i_sys_rst, .i_base_nibble(nib), .addr(bif.addr),
    .wdata(bif.wdata), .strobe(bif.strobe), .write(bif.write), .ack(bif.ack), .hit(bif.hit));

  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Remote address of a register
  function automatic logic [15:0] ra(input logic [2:0] sel);
    return {8'h00, nib, sel, 1'b1};
  endfunction

  // Local processor access
  task automatic loc(input logic w, input logic [2:0] sel, input logic [7:0] d, output logic [7:0] r);
    @(negedge i_clock);
    loc_strobe = 1'b1;
    loc_write = w;
    loc_addr = 32'hfffe2020 | {28'h0, sel, 1'b1};
    loc_wdata = d;
    @(negedge i_clock);
    loc_strobe = 1'b0;
    r = loc_rdata;
    if (loc_ack !== 1'b1) check("local ack", {7'h0, loc_ack}, 8'h01);
    check("local hit", {7'h0, loc_hit}, 8'h01);
  endtask

  // Remote master access
  task automatic rem(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r,
    output logic miss);
    @(negedge i_clock);
    req = 1'b1;
    rq_write = w;
    rq_addr = a;
    rq_wdata = d;
    // Request stands until the master reports the access finished or 60 cycles pass
    for (int k = 0; k < 60 && m_done !== 1'b1; k++) @(negedge i_clock);
    req = 1'b0;
    if (m_done !== 1'b1) check("remote done", {7'h0, m_done}, 8'h01);
    r = m_rdata;
    miss = m_miss;
  endtask

  ////////////////////////////////////////////////////////////////
  // Reset values of all registers
  task automatic t_reset();
    logic [7:0] r;
    logic [7:0] exp [8] = '{8'h00, 8'h40, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int s = 1; s < 8; s++) begin
      loc(1'b0, 3'(s), 8'h00, r);
      check("reset value", r, exp[s]);
    end
    check("irq idle", {5'h0, irq}, 8'h00);
    $display("reset test done");
  endtask

  // All-ones nibble keeps the set silent
  task automatic t_unmapped();
    logic [7:0] r;
    logic m;
    nib = 4'hf;
    rem(1'b1, ra(3'h1), 8'h01, r, m);
    check("unmapped miss", {7'h0, m}, 8'h01);
    check("unmapped irq", {5'h0, irq}, 8'h00);
    nib = 4'h3;
    loc(1'b0, 3'h1, 8'h00, r);
    check("unmapped write lost", r, 8'h40);
    $display("unmapped test done");
  endtask

  // Mailboxes both ways
  task automatic t_mail();
    logic [7:0] r;
    logic m;
    for (int s = 3; s < 8; s++) begin
      rem(1'b1, ra(3'(s)), 8'h50 + 8'(s), r, m);
      loc(1'b0, 3'(s), 8'h00, r);
      check("mailbox remote write", r, 8'h50 + 8'(s));
      loc(1'b1, 3'(s), 8'ha0 + 8'(s), r);
      rem(1'b0, ra(3'(s)), 8'h00, r, m);
      check("mailbox local write", r, 8'ha0 + 8'(s));
    end
    $display("mailbox test done");
  endtask

  // Identifier read-only remotely
  task automatic t_ident();
    logic [7:0] r;
    logic m;
    loc(1'b1, 3'h2, 8'ha5, r);
    rem(1'b1, ra(3'h2), 8'h3c, r, m);
    rem(1'b0, ra(3'h2), 8'h00, r, m);
    check("ident remote", r, 8'ha5);
    $display("ident test done");
  endtask

  // Signal bits and interrupt levels
  task automatic t_signal();
    logic [7:0] r;
    logic m;
    rem(1'b1, ra(3'h1), 8'h01, r, m);
    check("low irq", {5'h0, irq}, 8'h01);
    loc(1'b1, 3'h1, 8'h00, r);
    low_en = 1'b0;
    @(negedge i_clock);
    check("low masked", {5'h0, irq}, 8'h00);
    low_en = 1'b1;
    rem(1'b1, ra(3'h1), 8'h02, r, m);
    check("high irq", {5'h0, irq}, 8'h05);
    rem(1'b1, ra(3'h1), 8'h00, r, m);
    loc(1'b0, 3'h1, 8'h00, r);
    check("zero writes", r, 8'h43);
    nib = 4'hf;
    @(negedge i_clock);
    check("unmapped irq", {5'h0, irq}, 8'h00);
    nib = 4'h3;
    loc(1'b1, 3'h1, 8'h02, r);
    check("high cleared", {5'h0, irq}, 8'h01);
    loc(1'b1, 3'h1, 8'h01, r);
    check("low cleared", {5'h0, irq}, 8'h00);
    $display("signal test done");
  endtask

  // Fail status, inhibit and strap
  task automatic t_fail();
    logic [7:0] r;
    logic m;
    fail_pin = 1'b1;
    fail_req = 1'b1;
    repeat (6) @(negedge i_clock);
    loc(1'b0, 3'h1, 8'h00, r);
    check("fail status", r, 8'h50);
    check("fail drive", {7'h0, fail_drive}, 8'h01);
    rem(1'b1, ra(3'h1), 8'h20, r, m);
    check("fail inhibited", {7'h0, fail_drive}, 8'h00);
    loc(1'b0, 3'h1, 8'h00, r);
    check("inhibit keeps status", r, 8'h70);
    fail_pin = 1'b0;
    strap = 1'b0;
    repeat (6) @(negedge i_clock);
    loc(1'b0, 3'h1, 8'h00, r);
    check("fail and strap off", r, 8'h20);
    strap = 1'b1;
    $display("fail test done");
  endtask

  // Reset-and-hold, then reset in mid-run
  task automatic t_hold();
    logic [7:0] r;
    logic m;
    realtime t0;
    // Hold set waits while the local side runs a remote cycle
    local_busy = 1'b1;
    fork
      rem(1'b1, ra(3'h1), 8'h80, r, m);
      begin
        repeat (4) @(negedge i_clock);
        check("hold waits busy", {6'h0, busy, hold}, 8'h00);
        local_busy = 1'b0;
      end
    join
    check("hold set", {7'h0, hold}, 8'h01);
    t0 = $realtime;
    loc(1'b1, 3'h1, 8'h00, r);
    check("hold kept", {7'h0, hold}, 8'h01);
    rem(1'b1, ra(3'h1), 8'h00, r, m);
    check("hold cleared", {7'h0, hold}, 8'h00);
    check("hold span", {7'h0, ($realtime - t0) >= 100.0}, 8'h01);
    rem(1'b1, ra(3'h1), 8'ha1, r, m);
    i_sys_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_sys_rst = 1'b0;
    loc(1'b0, 3'h1, 8'h00, r);
    check("reset clears control", r, 8'h40);
    check("reset drops hold", {7'h0, hold}, 8'h00);
    $display("hold test done");
  endtask

  // Same-cycle accesses from both ports
  task automatic t_clash();
    logic [7:0] r, r2;
    logic m;
    fork
      rem(1'b1, ra(3'h3), 8'h11, r, m);
      begin
        @(negedge i_clock);
        loc(1'b1, 3'h3, 8'h22, r2);
      end
    join
    loc(1'b0, 3'h3, 8'h00, r);
    check("clash mailbox", r, 8'h22);
    fork
      rem(1'b1, ra(3'h1), 8'h01, r, m);
      begin
        @(negedge i_clock);
        loc(1'b1, 3'h1, 8'h01, r2);
      end
    join
    check("clash signal", {5'h0, irq}, 8'h01);
    $display("clash test done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    miscompares++;
    results();
  end

  // Main sequence
  initial begin
    {i_sys_rst, low_en, high_en, strap} = 4'hf;
    {loc_strobe, loc_write, fail_pin, fail_req, req, rq_write, local_busy} = 7'h00;
    nib = 4'h3;
    loc_addr = 32'h0;
    loc_wdata = 8'h00;
    rq_addr = 16'h0000;
    rq_wdata = 8'h00;
    repeat (5) @(negedge i_clock);
    i_sys_rst = 1'b0;
    t_reset();
    t_unmapped();
    t_mail();
    t_ident();
    t_signal();
    t_fail();
    t_hold();
    t_clash();
    results();
  end
endmodule

`default_nettype wire
